// File: core/fast_settle_timer.sv
// Fast settle timer: counts 2 x N reference ticks or holds while forced with nonzero N.
// Assumes ref_tick is a one-cycle pulse from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module fast_settle_timer
    import synth_cfg_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, power-on or register reset
    input wire logic start, // Frequency change pulse
    input wire logic ref_tick, // One pulse per reference cycle
    input wire logic [11:0] timeout, // Timeout value N
    input wire logic force_on, // Force fast settle
    output logic active, // Fast settle engaged
    output logic invalid // Forced with zero timeout
);
    fl_state_t state_r;
    logic [12:0] cnt_r;
    logic nz;
    logic hold;

    assign nz = (timeout != 12'h000);
    assign hold = force_on && nz;
    assign active = (state_r != FL_IDLE);
    assign invalid = force_on && !nz;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= FL_IDLE;
            cnt_r <= 13'h0000;
        end else begin
            unique case (state_r)
                FL_IDLE: begin
                    if (hold) begin
                        state_r <= FL_HOLD;
                    end else if (start && nz) begin
                        state_r <= FL_COUNT;
                        cnt_r <= {timeout, 1'b0};
                    end
                end
                FL_COUNT: begin
                    if (hold) begin
                        state_r <= FL_HOLD;
                    end else if (!nz) begin
                        state_r <= FL_IDLE;
                    end else if (start) begin
                        cnt_r <= {timeout, 1'b0};
                    end else if (ref_tick) begin
                        cnt_r <= cnt_r - 13'h0001;
                        if (cnt_r == 13'h0001) begin
                            state_r <= FL_IDLE;
                        end
                    end
                end
                FL_HOLD: begin
                    if (!hold) begin
                        state_r <= FL_IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_count_end: assert property (state_r == FL_COUNT && ref_tick && cnt_r == 13'h0001
        && !start && !hold && nz |=> !active)
        else $error("fast settle did not end after 2N ticks");
    chk_force_hold: assert property (hold |=> active)
        else $error("forced fast settle not engaged");
    chk_zero_off: assert property (!nz && !force_on |=> !active)
        else $error("fast settle active with zero timeout");
    cov_count_done: cover property (state_r == FL_COUNT ##1 state_r == FL_IDLE);
endmodule : fast_settle_timer
`default_nettype wire

// File: core/synth_cfg_pkg.sv
// Shared constants for the synthesizer configuration and control block.
// Assumes a single 100 MHz clock domain and synchronous active-high reset.
package synth_cfg_pkg;
    localparam int DATA_W = 32;
    localparam int IDX_W = 4;
    localparam int NUM_REGS = 16;
    localparam int SYNC_STAGES = 3;
    localparam int PIN_COUNT = 2;
    localparam int PIN_CE = 0;
    localparam int PIN_BUF = 1;

    // Register indices
    localparam logic [3:0] REG_CORE = 4'h2;
    localparam logic [3:0] REG_OUT = 4'h3;
    localparam logic [3:0] REG_FAST = 4'h4;
    localparam logic [3:0] REG_CTRL = 4'h5;

    // Control word fields
    localparam int RST_BIT = 31;
    localparam int LOCK_BIT = 30;
    localparam int PID_BIT = 29;
    localparam int RB_IDX_LSB = 25;
    localparam int PWR_LSB = 22;
    localparam int MODE_LSB = 20;
    localparam int RANGE_LSB = 17;
    localparam int BUFIGN_BIT = 16;
    localparam int MUTE_BIT = 15;
    // Output word fields
    localparam int FIRST_SRC_LSB = 0;
    localparam int SECOND_SRC_LSB = 2;
    localparam int DLY_FB_BIT = 4;
    // Fast settle word fields
    localparam int TIMEOUT_LSB = 0;
    localparam int TIMEOUT_W = 12;
    localparam int FORCE_BIT = 12;
    localparam int PUMP_LSB = 13;
    // Core selection word fields
    localparam int POLICY_LSB = 0;
    localparam int CORE_SEL_LSB = 2;

    // Reset values: readback index defaults to 15, all else zero
    localparam logic [31:0] CTRL_RESET_VAL = 32'h1E00_0000;
    localparam logic [31:0] WORD_RESET_VAL = 32'h0000_0000;
    // Arbitrary neutral identity value
    localparam logic [31:0] PART_ID_VAL = 32'h0000_5A01;

    // Source select codes
    localparam logic [1:0] SRC_OSC = 2'h0;
    localparam logic [1:0] SRC_DIV = 2'h1;
    localparam logic [1:0] SRC_FB = 2'h2;
    // Operating modes
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_PLL = 2'h1;
    // Core selection policies
    localparam logic [1:0] POL_LAST = 2'h0;
    localparam logic [1:0] POL_START = 2'h1;
    localparam logic [1:0] POL_FORCE = 2'h2;
    localparam logic [1:0] CORE_LOWEST = 2'h0;
    // Power state codes
    localparam logic [2:0] PWR_UP = 3'h0;
    localparam logic [2:0] PWR_DOWN = 3'h1;
    localparam logic [2:0] PWR_PARTIAL = 3'h3;
    localparam logic [2:0] PWR_CE = 3'h4;
    localparam logic [2:0] PWR_CE_PARTIAL = 3'h6;
    localparam logic [2:0] PWR_CE_INV = 3'h7;

    // Pump minimum on time in ps: 370,760,1130,1460,1770,2070,2350,2600
    localparam logic [11:0] PUMP_PS [8] = '{12'h172, 12'h2F8, 12'h46A, 12'h5B4,
                                            12'h6EA, 12'h816, 12'h92E, 12'hA28};

    typedef enum logic [2:0] {
        FL_IDLE = 3'b001,
        FL_COUNT = 3'b010,
        FL_HOLD = 3'b100
    } fl_state_t;
endpackage : synth_cfg_pkg

// File: core/synth_config_control.sv
// Configuration and control fields of a wideband synthesizer.
// Assumes writes arrive already deframed from the serial port, one word per pulse.
// How it works
// - ID select clear: read back indexed register
// - ID select set: read back part identity
// - Locked: ignore writes except the lock bit
// - Mute enabled: unlock powers down both outputs
// - Buffer pin ignored when ignore bit set
// - Policy 0: start at last or lowest core
// - Policy 1: start at selected core, may move
// - Policy 2: force selected core; 3 reserved
// - Second output source: oscillator, divider, feedback
// - First output source decoded the same way
// - Deterministic delay feeds detector from divider
// - Operating mode: full chip or PLL only
// - Power code 0 up, 1 down, 3 partial
// - Register 5 reset bit resets all but readback and pin synchronisers, self-releases
// - Pump minimum on time from delay code
// - Force with nonzero timeout holds fast settle
// - Fast settle lasts 2N reference cycles; 0 disables
`timescale 1ns/10ps
`default_nettype none
module synth_config_control
    import synth_cfg_pkg::*;
(
    input wire logic clk, // System clock, 100 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic wr_valid, // Deframed serial write strobe
    input wire logic [3:0] wr_index, // Register index of the write
    input wire logic [31:0] wr_data, // Register word of the write
    input wire logic chip_enable_pin, // Chip enable pin, asynchronous
    input wire logic output_buffer_enable_pin, // Buffer enable pin, asynchronous
    input wire logic lock_detect, // Digital lock detect, high when locked
    input wire logic cal_start, // Calibration start pulse
    input wire logic cal_core_invalid, // Current core found invalid, pulse
    input wire logic cal_done, // Calibration finished, pulse
    input wire logic [1:0] cal_core_used, // Core chosen by calibration
    input wire logic ref_tick, // One pulse per reference cycle
    output logic [31:0] readback_data, // Readback word
    output logic programming_lockout, // Lock bit state
    output logic first_rf_output_pd, // First output powered down
    output logic second_rf_output_pd, // Second output powered down
    output logic [2:0] first_output_source, // One-hot: osc, divider, feedback
    output logic [2:0] second_output_source, // One-hot: osc, divider, feedback
    output logic deterministic_delay_feedback, // Detector fed from divider
    output logic pll_power_on, // PLL powered
    output logic osc_power_on, // Internal oscillator powered
    output logic fb_input_power_on, // Feedback input powered
    output logic device_power_up, // Device fully powered
    output logic regulators_on, // Regulators kept on
    output logic [2:0] reference_range_code, // Reference range for calibration
    output logic [11:0] pump_min_pulse_ps, // Pump minimum on time, ps
    output logic [1:0] cal_core, // Core calibration works on
    output logic cal_core_fallback, // Calibration may leave the core
    output logic fast_settle_active, // Fast settle engaged
    output logic fast_settle_invalid // Forced with zero timeout
);
    logic [31:0] regs_r [NUM_REGS];
    logic soft_rst_r;
    logic rst_all;
    logic [31:0] ctrl_word;
    logic [31:0] out_word;
    logic [31:0] fast_word;
    logic [31:0] core_word;
    logic [31:0] rb_word;
    logic [3:0] rb_idx;
    logic part_identity_select;
    logic mute_on_unlock_enable;
    logic buffer_pin_ignore;
    logic [2:0] power_state_code;
    logic [1:0] op_mode;
    logic [1:0] policy;
    logic [1:0] core_select;
    logic [2:0] pump_min_pulse_code;
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_r;
    logic ce_level;
    logic buf_level;
    logic accept;
    logic muted;
    logic buffers_on;
    logic partial;
    logic last_valid_r;
    logic [1:0] last_core_r;

    function automatic logic [2:0] src_decode(input logic [1:0] code);
        unique case (code)
            SRC_OSC: src_decode = 3'b001;
            SRC_DIV: src_decode = 3'b010;
            SRC_FB: src_decode = 3'b100;
            default: src_decode = 3'b000; // Reserved code drives nothing
        endcase
    endfunction : src_decode

    assign rst_all = sys_rst || soft_rst_r;
    assign ctrl_word = regs_r[REG_CTRL];
    assign out_word = regs_r[REG_OUT];
    assign fast_word = regs_r[REG_FAST];
    assign core_word = regs_r[REG_CORE];
    assign rb_idx = ctrl_word[RB_IDX_LSB +: 4];
    assign rb_word = regs_r[rb_idx];
    assign programming_lockout = ctrl_word[LOCK_BIT];
    assign part_identity_select = ctrl_word[PID_BIT];
    assign mute_on_unlock_enable = ctrl_word[MUTE_BIT];
    assign buffer_pin_ignore = ctrl_word[BUFIGN_BIT];
    assign power_state_code = ctrl_word[PWR_LSB +: 3];
    assign op_mode = ctrl_word[MODE_LSB +: 2];
    assign reference_range_code = ctrl_word[RANGE_LSB +: 3];
    assign policy = core_word[POLICY_LSB +: 2];
    assign core_select = core_word[CORE_SEL_LSB +: 2];
    assign pump_min_pulse_code = fast_word[PUMP_LSB +: 3];
    assign accept = wr_valid && !programming_lockout;

    // Pin synchronisers: a level counts once stages two and three agree
    assign pin_raw = {output_buffer_enable_pin, chip_enable_pin};
    generate
        for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
            logic [SYNC_STAGES-1:0] sync_r;
            logic level_r;
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    sync_r <= 3'h0;
                    level_r <= 1'b0;
                end else begin
                    sync_r <= {sync_r[1:0], pin_raw[i]};
                    if (sync_r[1] == sync_r[2]) begin
                        level_r <= sync_r[2];
                    end
                end
            end
            // One driver per bit keeps the level vector free of shared writers
            assign pin_r[i] = level_r;
        end
    endgenerate
    assign ce_level = pin_r[PIN_CE];
    assign buf_level = pin_r[PIN_BUF];

    // Register file writes
    always_ff @(posedge clk) begin
        if (rst_all) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= WORD_RESET_VAL;
            end
            regs_r[REG_CTRL] <= CTRL_RESET_VAL;
        end else if (accept) begin
            if (!(wr_index == REG_CTRL && wr_data[RST_BIT])) begin
                regs_r[wr_index] <= wr_data & ~(32'h0000_0001 << RST_BIT);
            end
        end else if (wr_valid && wr_index == REG_CTRL) begin
            regs_r[REG_CTRL][LOCK_BIT] <= wr_data[LOCK_BIT];
        end
    end

    // Self-releasing register reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            soft_rst_r <= 1'b0;
        end else begin
            // Writes landing in the reset cycle are lost, so they cannot retrigger it
            soft_rst_r <= !soft_rst_r && accept && wr_index == REG_CTRL && wr_data[RST_BIT];
        end
    end

    // Readback
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readback_data <= WORD_RESET_VAL;
        end else if (part_identity_select) begin
            readback_data <= PART_ID_VAL;
        end else begin
            readback_data <= rb_word;
        end
    end

    // Power state decode, chip enable codes included
    always_comb begin
        device_power_up = 1'b0;
        partial = 1'b0;
        unique case (power_state_code)
            PWR_UP: device_power_up = 1'b1;
            PWR_PARTIAL: partial = 1'b1;
            PWR_CE: device_power_up = ce_level;
            PWR_CE_PARTIAL: begin
                device_power_up = ce_level;
                partial = !ce_level;
            end
            PWR_CE_INV: partial = ce_level;
            default: device_power_up = 1'b0; // Down and reserved codes
        endcase
    end
    assign regulators_on = device_power_up || partial;

    // Operating mode decode
    assign pll_power_on = device_power_up && (op_mode == MODE_FULL || op_mode == MODE_PLL);
    assign osc_power_on = device_power_up && op_mode == MODE_FULL;
    assign fb_input_power_on = 1'b0;

    // Output gating and source selects
    assign muted = mute_on_unlock_enable && !lock_detect;
    assign buffers_on = buffer_pin_ignore || buf_level;
    assign first_rf_output_pd = !device_power_up || muted || !buffers_on;
    assign second_rf_output_pd = !device_power_up || muted || !buffers_on;
    assign first_output_source = src_decode(out_word[FIRST_SRC_LSB +: 2]);
    assign second_output_source = src_decode(out_word[SECOND_SRC_LSB +: 2]);
    assign deterministic_delay_feedback = out_word[DLY_FB_BIT];

    // Pump minimum on time
    always_ff @(posedge clk) begin
        if (rst_all) begin
            pump_min_pulse_ps <= PUMP_PS[0];
        end else begin
            pump_min_pulse_ps <= PUMP_PS[pump_min_pulse_code];
        end
    end

    // Last used core memory
    always_ff @(posedge clk) begin
        if (rst_all) begin
            last_valid_r <= 1'b0;
            last_core_r <= CORE_LOWEST;
        end else if (cal_done) begin
            last_valid_r <= 1'b1;
            last_core_r <= cal_core_used;
        end
    end

    // Core selection policy
    always_ff @(posedge clk) begin
        if (rst_all) begin
            cal_core <= CORE_LOWEST;
        end else if (cal_start) begin
            if (policy == POL_START || policy == POL_FORCE) begin
                cal_core <= core_select;
            end else begin
                cal_core <= last_valid_r ? last_core_r : CORE_LOWEST;
            end
        end else if (cal_core_invalid && policy != POL_FORCE) begin
            cal_core <= cal_core + 2'h1;
        end
    end
    assign cal_core_fallback = (policy != POL_FORCE);

    fast_settle_timer u_fast (
        .clk(clk),
        .rst(rst_all),
        .start(cal_start),
        .ref_tick(ref_tick),
        .timeout(fast_word[TIMEOUT_LSB +: TIMEOUT_W]),
        .force_on(fast_word[FORCE_BIT]),
        .active(fast_settle_active),
        .invalid(fast_settle_invalid)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_readback_reg: assert property (!part_identity_select |=>
        readback_data == $past(rb_word))
        else $error("readback not the indexed register");
    chk_readback_id: assert property (part_identity_select |=>
        readback_data == PART_ID_VAL)
        else $error("readback not the part identity");
    chk_lockout_hold: assert property (programming_lockout && !soft_rst_r && wr_valid
        && wr_index == REG_OUT |=> out_word == $past(out_word))
        else $error("write accepted while locked");
    chk_mute_unlock: assert property (mute_on_unlock_enable && !lock_detect |->
        first_rf_output_pd && second_rf_output_pd)
        else $error("outputs not muted on unlock");
    chk_pin_ignore: assert property (buffer_pin_ignore && device_power_up && !muted
        |-> !first_rf_output_pd && !second_rf_output_pd)
        else $error("buffer pin not ignored");
    chk_forced_core: assert property (!soft_rst_r && cal_start && policy == POL_FORCE
        |-> !cal_core_fallback ##1 cal_core == $past(core_select))
        else $error("forced core not applied");
    chk_soft_reset: assert property (accept && !soft_rst_r && wr_index == REG_CTRL
        && wr_data[RST_BIT] |=> soft_rst_r ##1 !soft_rst_r && ctrl_word == CTRL_RESET_VAL)
        else $error("register reset did not restore and release");
    chk_power_ce: assert property (power_state_code == PWR_CE |->
        device_power_up == ce_level && !partial)
        else $error("chip enable power code wrong");
    chk_pump_code: assert property (!soft_rst_r ##1 !soft_rst_r |->
        pump_min_pulse_ps == PUMP_PS[$past(pump_min_pulse_code)])
        else $error("pump on time wrong");

    chk_locked_ctrl: assert property (programming_lockout && !soft_rst_r && wr_valid
        && wr_index == REG_CTRL |=> ctrl_word[PID_BIT:0] == $past(ctrl_word[PID_BIT:0]))
        else $error("locked control write changed a field");
    chk_first_core: assert property (!soft_rst_r && cal_start && policy == POL_LAST
        && !last_valid_r |=> cal_core == CORE_LOWEST)
        else $error("first calibration not at lowest core");
    chk_mode_power: assert property (osc_power_on |-> pll_power_on && device_power_up
        && !fb_input_power_on)
        else $error("oscillator powered without the PLL");

    cov_soft_reset: cover property (soft_rst_r ##1 !soft_rst_r);
    cov_id_read: cover property (part_identity_select ##1 readback_data == PART_ID_VAL);
    cov_mute: cover property (mute_on_unlock_enable && !lock_detect && device_power_up);
    cov_force_fast: cover property (fast_word[FORCE_BIT] && fast_settle_active);
endmodule : synth_config_control
`default_nettype wire

// File: test/host_writer.sv
// Host model: sends deframed register words, one per strobe.
// Assumes the bench calls send from its own process.
`timescale 1ns/10ps
`default_nettype none
module host_writer
    import synth_cfg_pkg::*;
(
    input wire logic clk, // System clock
    output logic wr_valid, // Write strobe
    output logic [3:0] wr_index, // Register index
    output logic [31:0] wr_data // Register word
);
    initial begin
        wr_valid = 1'b0;
        wr_index = 4'h0;
        wr_data = 32'h0000_0000;
    end
    // Callers pick only legal range codes policies and pump codes
    task automatic send(input logic [3:0] idx, input logic [31:0] data);
        @(negedge clk);
        wr_valid = 1'b1;
        wr_index = idx;
        wr_data = data;
        @(negedge clk);
        wr_valid = 1'b0;
        wr_index = ~idx;
        wr_data = ~data;
    endtask : send
endmodule : host_writer
`default_nettype wire

// File: test/tb_synth_config_control.sv
// Self-checking bench for the synthesizer configuration block.
// Assumes host_writer as the far-side model.
`timescale 1ns/10ps
`default_nettype none
module tb_synth_config_control;
    import synth_cfg_pkg::*;
    logic clk, sys_rst, ce, bp, ld, cs, ci, cd, rt;
    logic [1:0] cu;
    logic wv;
    logic [3:0] wi;
    logic [31:0] wd, rb;
    logic lko, pa, pb, dd, pll, osc, fb, up, rg, fi, fa, cf;
    logic [2:0] sa, sb, rr;
    logic [11:0] pp;
    logic [1:0] cc;
    int n_fail = 0;
    int total_checks = 0;
    synth_config_control synth_config_control_inst (.clk(clk), .sys_rst(sys_rst),
        .wr_valid(wv), .wr_index(wi), .wr_data(wd), .chip_enable_pin(ce),
        .output_buffer_enable_pin(bp), .lock_detect(ld), .cal_start(cs),
        .cal_core_invalid(ci), .cal_done(cd), .cal_core_used(cu), .ref_tick(rt),
        .readback_data(rb), .programming_lockout(lko), .first_rf_output_pd(pa),
        .second_rf_output_pd(pb), .first_output_source(sa), .second_output_source(sb),
        .deterministic_delay_feedback(dd), .pll_power_on(pll), .osc_power_on(osc),
        .fb_input_power_on(fb), .device_power_up(up), .regulators_on(rg),
        .reference_range_code(rr), .pump_min_pulse_ps(pp), .cal_core(cc),
        .cal_core_fallback(cf), .fast_settle_active(fa), .fast_settle_invalid(fi));
    host_writer host_writer_inst (.clk(clk), .wr_valid(wv), .wr_index(wi), .wr_data(wd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Fields: reset, lock, id, index, power, mode, buffer ignore, mute; range code 1
    function automatic logic [31:0] ctrl(logic rs, logic lk, logic id, logic [3:0] ri,
                                         logic [2:0] pw, logic [1:0] md, logic bi, logic mu);
        return {rs, lk, id, ri, pw, md, 3'h1, bi, mu, 15'h0000};
    endfunction : ctrl
    function automatic logic [2:0] hot(logic [1:0] c);
        return (c == 2'h3) ? 3'h0 : 3'h1 << c;
    endfunction : hot
    task automatic waitn(input int n);
        repeat (n) @(negedge clk);
    endtask : waitn
    task automatic strobe(input int k);
        @(negedge clk);
        case (k)
            0: cs = 1'b1;
            1: ci = 1'b1;
            2: cd = 1'b1;
            default: rt = 1'b1;
        endcase
        @(negedge clk);
        {cs, ci, cd, rt} = 4'h0;
    endtask : strobe
    task automatic t_reset();
        check("readback", rb, 32'h0000_0000);
        check("pump", pp, 32'h0000_0172);
        check("power", {up, lko, sa, cc}, {1'b1, 1'b0, 3'h1, 2'h0});
        check("out_pd_sync", {pa, pb}, 2'h3);
        waitn(4);
        check("out_pd", {pa, pb}, 2'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_sources();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            host_writer_inst.send(REG_OUT, {27'h0, c[0], ~c, c});
            check("first_src", sa, hot(c));
            check("second_src", sb, hot(~c));
            check("delay_fb", dd, c[0]);
        end
        host_writer_inst.send(REG_CTRL, ctrl(0, 0, 0, REG_OUT, 0, 0, 0, 0));
        waitn(1);
        check("rb_reg", rb, 32'h0000_0013);
        host_writer_inst.send(REG_CTRL, ctrl(0, 0, 1, REG_OUT, 0, 0, 0, 0));
        waitn(1);
        check("rb_id", rb, PART_ID_VAL);
        $display("t_sources done");
    endtask : t_sources
    task automatic t_power();
        logic u;
        logic p;
        for (int i = 0; i < 16; i++) begin
            ce = i[3];
            host_writer_inst.send(REG_CTRL, ctrl(0, 0, 0, 4'hF, i[2:0], 0, 0, 0));
            waitn(4);
            u = (i[2:0] == 0) || (ce && (i[2:0] == 4 || i[2:0] == 6));
            p = (i[2:0] == 3) || (!ce && i[2:0] == 6) || (ce && i[2:0] == 7);
            check("dev_up", up, u);
            check("regs_on", rg, u | p);
            check("range", rr, 3'h1);
        end
        for (int m = 0; m < 4; m++) begin
            host_writer_inst.send(REG_CTRL, ctrl(0, 0, 0, 4'hF, 0, m[1:0], 0, 0));
            check("mode", {pll, osc, fb}, {m < 2, m == 0, 1'b0});
        end
        $display("t_power done");
    endtask : t_power
    task automatic t_mute();
        ld = 1'b0;
        host_writer_inst.send(REG_CTRL, ctrl(0, 0, 0, 4'hF, 0, 0, 0, 1));
        check("mute_unlock", {pa, pb}, 2'h3);
        ld = 1'b1;
        waitn(1);
        check("mute_lock", {pa, pb}, 2'h0);
        ld = 1'b0;
        host_writer_inst.send(REG_CTRL, ctrl(0, 0, 0, 4'hF, 0, 0, 0, 0));
        check("no_mute", {pa, pb}, 2'h0);
        bp = 1'b0;
        waitn(5);
        check("buf_pin", {pa, pb}, 2'h3);
        host_writer_inst.send(REG_CTRL, ctrl(0, 0, 0, 4'hF, 0, 0, 1, 0));
        check("buf_ignored", {pa, pb}, 2'h0);
        bp = 1'b1;
        ld = 1'b1;
        $display("t_mute done");
    endtask : t_mute
    task automatic t_pump();
        logic [11:0] ps [8] = '{12'h172, 12'h2F8, 12'h46A, 12'h5B4,
                                12'h6EA, 12'h816, 12'h92E, 12'hA28};
        for (int i = 7; i >= 0; i--) begin
            host_writer_inst.send(REG_FAST, {16'h0, i[2:0], 13'h0000});
            waitn(1);
            check("pump_ps", pp, ps[i]);
        end
        $display("t_pump done");
    endtask : t_pump
    task automatic t_lock();
        host_writer_inst.send(REG_OUT, 32'h0000_0000);
        host_writer_inst.send(REG_CTRL, ctrl(0, 1, 0, 4'hF, 0, 0, 0, 0));
        host_writer_inst.send(REG_OUT, 32'h0000_0005);
        check("locked_wr", {lko, sa}, {1'b1, 3'h1});
        host_writer_inst.send(REG_CTRL, ctrl(1, 1, 0, 4'hF, 0, 0, 0, 0));
        waitn(2);
        check("locked_rst", lko, 1'b1);
        host_writer_inst.send(REG_CTRL, ctrl(0, 0, 0, 4'hF, 0, 0, 0, 1));
        check("unlock", {lko, pa}, 2'h0);
        host_writer_inst.send(REG_OUT, 32'h0000_0005);
        check("unlocked_wr", sa, 3'h2);
        $display("t_lock done");
    endtask : t_lock
    task automatic t_soft_reset();
        host_writer_inst.send(REG_FAST, 32'h0000_A000);
        host_writer_inst.send(REG_CTRL, ctrl(1, 0, 0, 4'h3, 0, 0, 0, 0));
        waitn(3);
        check("sr_fields", {sa, pp}, {3'h1, 12'h172});
        host_writer_inst.send(REG_CTRL, ctrl(0, 0, 0, 4'h5, 0, 0, 0, 0));
        waitn(1);
        check("sr_normal", rb, ctrl(0, 0, 0, 4'h5, 0, 0, 0, 0));
        $display("t_soft_reset done");
    endtask : t_soft_reset
    task automatic t_core();
        strobe(1);
        strobe(0);
        check("pol0_first", cc, 2'h0);
        cu = 2'h3;
        strobe(2);
        strobe(0);
        check("pol0_last", cc, 2'h3);
        host_writer_inst.send(REG_CORE, 32'h0000_0009);
        strobe(0);
        check("pol1_start", {cc, cf}, {2'h2, 1'b1});
        strobe(1);
        check("pol1_move", cc, 2'h3);
        host_writer_inst.send(REG_CORE, 32'h0000_0006);
        strobe(0);
        strobe(1);
        check("pol2_force", {cc, cf}, {2'h1, 1'b0});
        $display("t_core done");
    endtask : t_core
    task automatic t_fast();
        host_writer_inst.send(REG_FAST, 32'h0000_0001);
        strobe(0);
        check("fs_on", fa, 1'b1);
        strobe(3);
        check("fs_count", fa, 1'b1);
        strobe(3);
        waitn(1);
        check("fs_off", fa, 1'b0);
        host_writer_inst.send(REG_FAST, 32'h0000_0000);
        strobe(0);
        check("fs_zero", fa, 1'b0);
        host_writer_inst.send(REG_FAST, 32'h0000_1003);
        repeat (8) strobe(3);
        check("fs_force", {fa, fi}, 2'h2);
        host_writer_inst.send(REG_FAST, 32'h0000_1000);
        waitn(1);
        check("fs_invalid", {fa, fi}, 2'h1);
        $display("t_fast done");
    endtask : t_fast
    initial begin
        {sys_rst, ce, bp, ld, cs, ci, cd, rt, cu} = {1'b1, 1'b0, 1'b1, 1'b1, 6'h00};
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        waitn(1);
        t_reset();
        t_sources();
        t_power();
        t_mute();
        t_pump();
        t_lock();
        t_soft_reset();
        t_core();
        t_fast();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule : tb_synth_config_control
`default_nettype wire
